// ### include/lin_mode_pkg.sv
// Shared types and constants of the LIN transceiver mode control
package lin_mode_pkg;

  // Operating modes, Gray coded along standby, normal, sleep
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_NORMAL  = 2'h1,
    MODE_SLEEP   = 2'h3,
    MODE_SHORT   = 2'h2
  } mode_e;

  // Time base and wake filter time
  localparam int CLOCK_MHZ = 50;
  localparam int WAKE_FILTER_US = 40;
  localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CLOCK_MHZ;
  localparam int FILT_CNT_W = 12;

  // Synchronised pin group, lsb first: en, tx, bus, wake, floats, thermal
  typedef struct packed {
    logic cooled;
    logic hot;
    logic tx_float;
    logic en_float;
    logic wake;
    logic bus;
    logic tx;
    logic en;
  } pins_s;

  localparam int PINS_W = 8;
  // Reset image: enable low, transmit and bus recessive
  localparam logic [7:0] PINS_RESET = 8'h06;

  // Bus levels
  localparam logic BUS_DOMINANT = 1'b0;
  localparam logic BUS_RECESSIVE = 1'b1;

  // Output reset values
  localparam logic INH_RESET = 1'b1;
  localparam logic RX_RESET = 1'b1;
  localparam logic RX_OE_RESET = 1'b1;
  localparam logic BUS_OE_RESET = 1'b0;
  localparam logic HOT_RESET = 1'b0;

  // Whole control state of the top module
  typedef struct packed {
    mode_e mode;
    logic regulator_inhibit_out;
    logic rx;
    logic rx_oe;
    logic bus_oe;
    logic bus_o;
    logic hot;
  } ctrl_s;

endpackage

// ### src/pin_sync.sv
// Three-stage synchroniser whose output moves when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // Stage one feeds stage two only; per-bit agreement gates the output
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= {RST, RST, RST, RST};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule
`default_nettype wire

// ### src/wake_filter.sv
// Persistence filter: a new level counts only after it holds the filter time
`timescale 1ns/10ps
`default_nettype none
module wake_filter #(
  parameter logic RST = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic d,
  output logic level,
  output logic edge_p
);
  localparam logic [lin_mode_pkg::FILT_CNT_W-1:0] LAST =
    lin_mode_pkg::FILT_CNT_W'(lin_mode_pkg::WAKE_FILTER_CYC - 1);

  typedef struct packed {
    logic [lin_mode_pkg::FILT_CNT_W-1:0] cnt;
    logic level;
    logic edge_p;
  } filt_s;

  filt_s st_reg;
  filt_s st_next;

  // Any return to the old level restarts the count, so glitches die here
  always_comb begin
    st_next = st_reg;
    st_next.edge_p = 1'b0;
    if (d == st_reg.level) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == LAST) begin
      st_next.cnt = '0;
      st_next.level = d;
      st_next.edge_p = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= {{lin_mode_pkg::FILT_CNT_W{1'b0}}, RST, 1'b0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;
  assign edge_p = st_reg.edge_p;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_filter_hold: assert property (
    ce && d != st_reg.level && st_reg.cnt != LAST |=> $stable(st_reg.level)
  ) else $error("filtered level moved before filter time");

endmodule
`default_nettype wire

// ### src/lin_mode_control.sv
// Mode control of a single-wire LIN transceiver: normal, standby, sleep, short
//
// What this block does
// - Enable falling while bus held dominant by a short enters short-circuit mode.
// - Entering short-circuit mode drops the regulator inhibit output low.
// - In short-circuit mode the receive output is released to high impedance.
// - In short-circuit mode transmit input is ignored and the bus is undriven.
// - Short-circuit mode lasts while bus dominant, then goes to sleep directly.
// - Enable low in normal mode enters sleep unless a local wake edge or a bus short is present.
// - Entering sleep drops the inhibit output and blocks transmission.
// - Sleep goes to standby on bus dominant or local wake edge.
// - Bus and local wake inputs are filtered against glitches.
// - Enable high in sleep moves directly to normal mode.
// - Every valid wake-up raises the inhibit output.
// - Remote wake-up drives the receive output active and dominant.
// - Undriven transmit and enable inputs default so the bus stays recessive.
// - Thermal shutdown turns bus driver off until cooled to switch-on level.
// - Reset or a bus or local wake from sleep gives standby: receive only, inhibit high.
// - Normal mode is entered only from standby or sleep with enable high.
// - Normal mode drives transmit onto bus and mirrors bus on receive.
`timescale 1ns/10ps
`default_nettype none
module lin_mode_control (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic ENABLE_IN,
  input wire logic EN_FLOAT_IN,
  input wire logic TX_DATA_IN,
  input wire logic TX_FLOAT_IN,
  input wire logic BUS_IN,
  input wire logic LOCAL_WAKE_IN,
  input wire logic THERM_SHUTDOWN_IN,
  input wire logic THERM_COOLED_IN,
  output logic BUS_OUT,
  output logic BUS_OE,
  output logic RX_DATA_OUT,
  output logic RX_DATA_OE,
  output logic REGULATOR_INHIBIT_OUT,
  output logic [1:0] MODE_OUT
);

  lin_mode_pkg::pins_s pins_raw;
  lin_mode_pkg::pins_s pins;
  logic bus_level;
  logic bus_edge;
  logic wake_level;
  logic wake_edge;
  logic en_eff;
  logic tx_eff;
  logic bus_dom;
  logic bus_wake;
  lin_mode_pkg::ctrl_s st_reg;
  lin_mode_pkg::ctrl_s st_next;

  // Gather the pins so they cross into the clock domain together
  always_comb begin
    pins_raw.en = ENABLE_IN;
    pins_raw.tx = TX_DATA_IN;
    pins_raw.bus = BUS_IN;
    pins_raw.wake = LOCAL_WAKE_IN;
    pins_raw.en_float = EN_FLOAT_IN;
    pins_raw.tx_float = TX_FLOAT_IN;
    pins_raw.hot = THERM_SHUTDOWN_IN;
    pins_raw.cooled = THERM_COOLED_IN;
  end

  pin_sync #(
    .W(lin_mode_pkg::PINS_W),
    .RST(lin_mode_pkg::PINS_RESET)
  ) u_sync (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .ce(CLK_EN),
    .d(pins_raw),
    .q(pins)
  );

  // Wake sources pass the persistence filter
  wake_filter #(
    .RST(lin_mode_pkg::BUS_RECESSIVE)
  ) u_bus_filter (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .ce(CLK_EN),
    .d(pins.bus),
    .level(bus_level),
    .edge_p(bus_edge)
  );

  wake_filter #(
    .RST(1'b0)
  ) u_wake_filter (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .ce(CLK_EN),
    .d(pins.wake),
    .level(wake_level),
    .edge_p(wake_edge)
  );

  // Floating pins fall back to enable low and transmit recessive
  assign en_eff = pins.en & ~pins.en_float;
  assign tx_eff = pins.tx | pins.tx_float;
  assign bus_dom = (pins.bus == lin_mode_pkg::BUS_DOMINANT);
  // Only a filtered fall to dominant counts as a remote wake
  assign bus_wake = bus_edge && (bus_level == lin_mode_pkg::BUS_DOMINANT);

  // Mode sequencing, thermal latch and registered pin values
  always_comb begin
    st_next = st_reg;
    // Shutdown has priority so a hot die never re-enables the driver
    if (pins.hot) begin
      st_next.hot = 1'b1;
    end else if (pins.cooled) begin
      st_next.hot = 1'b0;
    end
    case (st_reg.mode)
      lin_mode_pkg::MODE_STANDBY: begin
        if (en_eff) begin
          st_next.mode = lin_mode_pkg::MODE_NORMAL;
        end
      end
      lin_mode_pkg::MODE_NORMAL: begin
        if (!en_eff) begin
          // Dominant bus that we are not pulling means a short to ground
          if (bus_dom && !st_reg.bus_oe) begin
            st_next.mode = lin_mode_pkg::MODE_SHORT;
          end else if (wake_edge) begin
            st_next.mode = lin_mode_pkg::MODE_STANDBY;
          end else begin
            st_next.mode = lin_mode_pkg::MODE_SLEEP;
          end
        end
      end
      lin_mode_pkg::MODE_SLEEP: begin
        if (en_eff) begin
          st_next.mode = lin_mode_pkg::MODE_NORMAL;
        end else if (bus_wake || wake_edge) begin
          st_next.mode = lin_mode_pkg::MODE_STANDBY;
        end
      end
      lin_mode_pkg::MODE_SHORT: begin
        // No reset needed: a cleared short falls straight to sleep
        if (!bus_dom) begin
          st_next.mode = lin_mode_pkg::MODE_SLEEP;
        end
      end
      default: begin
        st_next.mode = lin_mode_pkg::MODE_STANDBY;
      end
    endcase

    // Inhibit high only while awake
    st_next.regulator_inhibit_out = (st_next.mode == lin_mode_pkg::MODE_STANDBY) ||
                  (st_next.mode == lin_mode_pkg::MODE_NORMAL);
    // Receive released in short mode, idle high in sleep, else mirrors bus
    st_next.rx_oe = (st_next.mode != lin_mode_pkg::MODE_SHORT);
    if (st_next.mode == lin_mode_pkg::MODE_SLEEP) begin
      st_next.rx = lin_mode_pkg::BUS_RECESSIVE;
    end else begin
      st_next.rx = pins.bus;
    end
    // Open-drain driver pulls low only in normal mode on dominant data
    st_next.bus_oe = (st_next.mode == lin_mode_pkg::MODE_NORMAL) &&
                     (tx_eff == lin_mode_pkg::BUS_DOMINANT) &&
                     !st_next.hot;
    st_next.bus_o = lin_mode_pkg::BUS_DOMINANT;
  end

  // One register for the whole control state; clock enable freezes it
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg.mode <= lin_mode_pkg::MODE_STANDBY;
      st_reg.regulator_inhibit_out <= lin_mode_pkg::INH_RESET;
      st_reg.rx <= lin_mode_pkg::RX_RESET;
      st_reg.rx_oe <= lin_mode_pkg::RX_OE_RESET;
      st_reg.bus_oe <= lin_mode_pkg::BUS_OE_RESET;
      st_reg.bus_o <= lin_mode_pkg::BUS_DOMINANT;
      st_reg.hot <= lin_mode_pkg::HOT_RESET;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // Ports straight from the state register
  assign BUS_OUT = st_reg.bus_o;
  assign BUS_OE = st_reg.bus_oe;
  assign RX_DATA_OUT = st_reg.rx;
  assign RX_DATA_OE = st_reg.rx_oe;
  assign REGULATOR_INHIBIT_OUT = st_reg.regulator_inhibit_out;
  assign MODE_OUT = st_reg.mode;

  // Checks on mode sequencing and outputs
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  a_short_entry: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_NORMAL && !en_eff && bus_dom &&
    !st_reg.bus_oe |=> st_reg.mode == lin_mode_pkg::MODE_SHORT
  ) else $error("short to ground did not enter short mode");

  a_short_outputs: assert property (
    st_reg.mode == lin_mode_pkg::MODE_SHORT |-> !REGULATOR_INHIBIT_OUT && !RX_DATA_OE
  ) else $error("short mode left inhibit high or receive driven");

  a_short_no_drive: assert property (
    st_reg.mode == lin_mode_pkg::MODE_SHORT |-> !BUS_OE
  ) else $error("bus driven in short mode");

  a_short_exit: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_SHORT && !bus_dom
    |=> st_reg.mode == lin_mode_pkg::MODE_SLEEP
  ) else $error("cleared short did not go to sleep");

  a_sleep_entry: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_NORMAL && !en_eff && !bus_dom &&
    !wake_edge |=> st_reg.mode == lin_mode_pkg::MODE_SLEEP && !REGULATOR_INHIBIT_OUT
  ) else $error("enable low in normal mode did not enter sleep");

  a_local_wake: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_SLEEP && !en_eff && wake_edge
    |=> st_reg.mode == lin_mode_pkg::MODE_STANDBY ##0 REGULATOR_INHIBIT_OUT
  ) else $error("local wake edge ignored in sleep");

  a_enable_wake: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_SLEEP && en_eff
    |=> st_reg.mode == lin_mode_pkg::MODE_NORMAL && REGULATOR_INHIBIT_OUT
  ) else $error("enable high in sleep did not reach normal mode");

  a_inhibit_rise: assert property (
    $rose(REGULATOR_INHIBIT_OUT) |-> $past(st_reg.mode) == lin_mode_pkg::MODE_SLEEP
  ) else $error("inhibit rose without a wake from sleep");

  a_remote_wake_rx: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_SLEEP && !en_eff && bus_wake && bus_dom
    |=> RX_DATA_OE && !RX_DATA_OUT && REGULATOR_INHIBIT_OUT
  ) else $error("remote wake did not show dominant on receive");

  a_hot_off: assert property (
    st_reg.hot |-> !BUS_OE
  ) else $error("bus driven while over temperature");

  a_idle_no_tx: assert property (
    st_reg.mode != lin_mode_pkg::MODE_NORMAL |-> !BUS_OE
  ) else $error("bus driven outside normal mode");

  a_normal_drive: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_NORMAL && en_eff && !tx_eff &&
    !pins.hot && !st_reg.hot |=> BUS_OE && !BUS_OUT
  ) else $error("dominant transmit not driven in normal mode");

  // Sleep stays quiet until a filtered wake or enable high; standby only listens
  a_sleep_quiet: assert property (
    st_reg.mode == lin_mode_pkg::MODE_SLEEP
    |-> !BUS_OE && !REGULATOR_INHIBIT_OUT && RX_DATA_OUT
  ) else $error("sleep mode drives bus or keeps inhibit high");

  a_sleep_hold: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_SLEEP && !en_eff && !bus_wake && !wake_edge
    |=> st_reg.mode == lin_mode_pkg::MODE_SLEEP
  ) else $error("sleep left without a filtered wake");

  a_standby_rx: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_STANDBY && !en_eff
    |=> RX_DATA_OE && RX_DATA_OUT == $past(pins.bus) && REGULATOR_INHIBIT_OUT && !BUS_OE
  ) else $error("standby does not mirror the bus");

  a_normal_gate: assert property (
    CLK_EN && st_reg.mode != lin_mode_pkg::MODE_NORMAL && !en_eff
    |=> st_reg.mode != lin_mode_pkg::MODE_NORMAL
  ) else $error("normal mode entered without enable");

  // Loopback read-back lags the synchronised pin by one register stage
  a_rx_mirror: assert property (
    CLK_EN && st_reg.mode == lin_mode_pkg::MODE_NORMAL && en_eff
    |=> RX_DATA_OE && RX_DATA_OUT == $past(pins.bus)
  ) else $error("normal mode receive does not mirror the bus");

  c_short_cycle: cover property (
    st_reg.mode == lin_mode_pkg::MODE_SHORT ##1 st_reg.mode == lin_mode_pkg::MODE_SLEEP
  );
  c_remote_wake: cover property (
    st_reg.mode == lin_mode_pkg::MODE_SLEEP && bus_wake
  );
  c_local_wake: cover property (
    st_reg.mode == lin_mode_pkg::MODE_SLEEP && wake_edge
  );
  c_hot_normal: cover property (
    st_reg.mode == lin_mode_pkg::MODE_NORMAL && st_reg.hot
  );
  c_wake_at_sleep: cover property (
    st_reg.mode == lin_mode_pkg::MODE_NORMAL && !en_eff && wake_edge
  );

endmodule
`default_nettype wire

// ### verif/lin_bus_model.sv
// Far side of the LIN wire: pull-up, remote nodes and a short to ground
`timescale 1ns/10ps
`default_nettype none
module lin_bus_model (
  input wire logic bus_oe,
  input wire logic bus_o,
  input wire logic remote_dom,
  input wire logic short_gnd,
  output logic bus_level
);
  // Wired-AND over the pull-up; a released wire reads recessive unless a remote node or the short pulls it, never the last value
  assign bus_level = (bus_oe ? bus_o : 1'b1) & ~remote_dom & ~short_gnd;
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench of the LIN transceiver mode control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int FILT = lin_mode_pkg::WAKE_FILTER_CYC;
  localparam int LAT = 6;
  localparam int CEILING = 40000;
  logic clock, reset_n, clk_en, enable_in, en_float, tx_data, tx_float;
  logic local_wake, hot, cooled, remote_dom, short_gnd, bus_level;
  logic bus_out, bus_oe, rx_data, rx_oe, inhibit;
  logic [1:0] mode;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  lin_mode_control dut_u (
    .CLOCK(clock), .RESET_N(reset_n), .CLK_EN(clk_en), .ENABLE_IN(enable_in),
    .EN_FLOAT_IN(en_float), .TX_DATA_IN(tx_data), .TX_FLOAT_IN(tx_float),
    .BUS_IN(bus_level), .LOCAL_WAKE_IN(local_wake), .THERM_SHUTDOWN_IN(hot),
    .THERM_COOLED_IN(cooled), .BUS_OUT(bus_out), .BUS_OE(bus_oe), .RX_DATA_OUT(rx_data),
    .RX_DATA_OE(rx_oe), .REGULATOR_INHIBIT_OUT(inhibit), .MODE_OUT(mode)
  );

  lin_bus_model bus_u (
    .bus_oe(bus_oe), .bus_o(bus_out), .remote_dom(remote_dom), .short_gnd(short_gnd),
    .bus_level(bus_level)
  );

  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Hang guard; the budget is several times the longest sequence
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == CEILING) begin
      err_total = err_total + 1;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Receive data is only judged while the pin is driven
  task automatic expect_state(input logic [1:0] m, input logic regulator_inhibit_out, input logic rx,
      input logic roe, input logic boe, input string what);
    total_checks = total_checks + 1;
    if (mode !== m || inhibit !== regulator_inhibit_out || rx_oe !== roe || bus_oe !== boe ||
        (roe && rx_data !== rx) || bus_out !== 1'b0) begin
      err_total = err_total + 1;
      $display("Error at %0t: %s mode=%h inh=%b rx=%b roe=%b boe=%b", $time, what, mode,
        inhibit, rx_data, rx_oe, bus_oe);
    end
  endtask

  task automatic drive(input logic en, input logic tx, input logic rdom, input logic sh);
    @(posedge clock);
    enable_in <= en;
    tx_data <= tx;
    remote_dom <= rdom;
    short_gnd <= sh;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic to_sleep();
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(LAT);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "sleep entry");
  endtask

  task automatic t_standby();
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b1, 1'b1, 1'b0, "standby tx");
    drive(1'b0, 1'b1, 1'b1, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b0, 1'b1, 1'b0, "standby rx");
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(LAT);
  endtask

  // Loopback: own dominant bit must come back on the receive pin
  task automatic t_normal();
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "enter normal");
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b0, 1'b1, 1'b1, "tx dominant");
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "tx recessive");
  endtask

  task automatic t_bus_wake();
    to_sleep();
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "sleep tx");
    drive(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (100) @(posedge clock);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(FILT + 50);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "bus glitch");
    drive(1'b0, 1'b1, 1'b1, 1'b0);
    settle(FILT - 20);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "early wake");
    settle(40);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b0, 1'b1, 1'b0, "bus wake");
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(LAT);
  endtask

  // Both wake edges, after a pulse too short to count
  task automatic t_local_wake();
    to_sleep();
    @(posedge clock);
    local_wake <= 1'b1;
    repeat (50) @(posedge clock);
    local_wake <= 1'b0;
    settle(FILT + 50);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "wake glitch");
    @(posedge clock);
    local_wake <= 1'b1;
    settle(FILT + 30);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b1, 1'b1, 1'b0, "wake rise");
    to_sleep();
    @(posedge clock);
    local_wake <= 1'b0;
    settle(FILT + 30);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b1, 1'b1, 1'b0, "wake fall");
  endtask

  task automatic t_enable_wake();
    to_sleep();
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "enable wake");
    // Enable falls in the very cycle the filtered wake edge appears
    @(posedge clock);
    local_wake <= 1'b1;
    repeat (FILT) @(posedge clock);
    enable_in <= 1'b0;
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b1, 1'b1, 1'b0, "wake at sleep");
  endtask

  task automatic t_short();
    drive(1'b1, 1'b1, 1'b0, 1'b1);
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b0, 1'b1, 1'b0, "shorted bus");
    drive(1'b0, 1'b1, 1'b0, 1'b1);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_SHORT, 1'b0, 1'b0, 1'b0, 1'b0, "short entry");
    for (int i = 0; i < 4; i++) begin
      drive(1'b0, i[0], 1'b0, 1'b1);
      settle(LAT);
      expect_state(lin_mode_pkg::MODE_SHORT, 1'b0, 1'b0, 1'b0, 1'b0, "short tx");
    end
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "short exit");
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(LAT);
  endtask

  // Driver stays off between the two temperature thresholds
  task automatic t_thermal();
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clock);
    hot <= 1'b1;
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "over temp");
    @(posedge clock);
    hot <= 1'b0;
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "cooling");
    @(posedge clock);
    cooled <= 1'b1;
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b0, 1'b1, 1'b1, "cooled");
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    cooled <= 1'b0;
    settle(12);
  endtask

  task automatic t_float();
    @(posedge clock);
    tx_float <= 1'b1;
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    settle(12);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "tx float");
    @(posedge clock);
    en_float <= 1'b1;
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "en float");
    // Clock enable low must freeze even the synchronisers
    @(posedge clock);
    clk_en <= 1'b0;
    en_float <= 1'b0;
    settle(12);
    expect_state(lin_mode_pkg::MODE_SLEEP, 1'b0, 1'b1, 1'b1, 1'b0, "frozen");
    @(posedge clock);
    clk_en <= 1'b1;
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "unfrozen");
    // Reset in mid-run returns to standby, then enable leads to normal
    @(posedge clock);
    reset_n <= 1'b0;
    settle(2);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b1, 1'b1, 1'b0, "mid reset");
    @(posedge clock);
    reset_n <= 1'b1;
    settle(LAT);
    expect_state(lin_mode_pkg::MODE_NORMAL, 1'b1, 1'b1, 1'b1, 1'b0, "after reset");
  endtask

  // Main sequence: power-up reset, then every mode path
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    enable_in = 1'b0;
    en_float = 1'b0;
    tx_data = 1'b1;
    tx_float = 1'b0;
    local_wake = 1'b0;
    hot = 1'b0;
    cooled = 1'b0;
    remote_dom = 1'b0;
    short_gnd = 1'b0;
    settle(2);
    expect_state(lin_mode_pkg::MODE_STANDBY, 1'b1, 1'b1, 1'b1, 1'b0, "reset");
    @(posedge clock);
    reset_n <= 1'b1;
    t_standby();
    t_normal();
    t_bus_wake();
    t_local_wake();
    t_enable_wake();
    t_short();
    t_thermal();
    t_float();
    summarize();
  end
endmodule
`default_nettype wire
